//--- src/pra_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Parallel host port between processor and device
interface pra_bus_if;
   logic       bus_muxed;   // 1: multiplexed bus, 0: dedicated
   logic       ale;         // Address phase strobe, muxed bus
   logic [7:0] ad;          // Host data, also address in muxed phase
   logic [2:0] addr_ded;    // Dedicated address lines
   logic       rd;
   logic       wr;
   logic [7:0] rdata;
   logic       rvalid;

   modport host (output bus_muxed, ale, ad, addr_ded, rd, wr,
                 input  rdata, rvalid);
   modport dev  (input  bus_muxed, ale, ad, addr_ded, rd, wr,
                 output rdata, rvalid);
endinterface
`default_nettype wire

//--- src/pra_consts.svh
`ifndef PRA_CONSTS_SVH
`define PRA_CONSTS_SVH
// Behaviour
// RQ1: Decode 64 registers from six-bit address.
// RQ2: Eight pages of eight; page bits on top.
// RQ3: Page register reachable from every page.
// RQ4: Dedicated bus gives three low address bits.
// RQ5: Dedicated bus uses stored page number.
// RQ6: Muxed bus latches six bits per address phase.
// RQ7: Muxed: paging or linear by enable bit.
// RQ8: Read/write bits never changed by hardware.
// RQ9: Dynamic bits also updated by engine.
// RQ10: Read-only flags ignore host writes.
// RQ11: Write-only reads return undefined value.
// RQ12: Host writes expected values; don't-care free.
// RQ13: Page register at sub-offset zero everywhere.
// RQ14: Page fields held until rewrite or reset.

// ==========================================
// Address layout
`define PRA_ADDR_W    6
`define PRA_SUB_W     3
`define PRA_NUM_REGS  64
`define PRA_SUB_PAGE  3'h0
`define PRA_WO_PAGE   3'h7
`define PRA_ADDR_CMD  6'h01
`define PRA_ADDR_ERR  6'h0a
`define PRA_ADDR_TRLD 6'h23

// ==========================================
// Page register fields and reset values
`define PRA_PME_BIT   7
`define PRA_PAGE_HI   2
`define PRA_PAGE_LO   0
`define PRA_PAGE_RST  8'h80
`define PRA_PME_RST   1'h1
`define PRA_PNUM_RST  3'h0
`define PRA_REG_RST   8'h00
`define PRA_CMD_IDLE  8'h00
`endif

//--- src/pra_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "pra_consts.svh"
module pra_device
   import pra_pkg::*;
#(
   parameter pra_byte_t UNDEF_READ = 8'h00   // Arbitrary filler for write-only reads
)(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Host port
   pra_bus_if.dev          bus,
   // Internal engine side
   input  wire logic       cmd_done,
   input  wire logic [7:0] err_flags_in,
   // Register contents seen by the engine
   output logic [7:0]      command_reg,
   output logic [7:0]      timer_reload_reg,
   output logic [7:0]      error_flags_reg,
   output logic            page_mode_enable,
   output logic [2:0]      page_number,
   // Write notification
   output logic            wr_strobe,
   output pra_addr_t       wr_addr,
   output pra_byte_t       wr_data
);

   // ==========================================
   // Access classes
   // Page slot: sub-offset zero of every page, holds paging state.
   // Read/write: host owns the value, the engine only samples it.
   // Dynamic: command slot, host writes it and the engine clears it.
   // Read-only: error flags follow the engine, host writes are dropped.
   // Write-only: top page, reads answer filler instead of content.
   // Sub-offset zero wins over every other class in the decode.

   // ==========================================
   // Address formation

   // Assemble the six-bit register address from the bus and page state
   // Pure decode, no state; every access goes through it.
   function automatic pra_addr_t form_addr(
      input logic       muxed,
      input logic       pme,
      input logic [2:0] page,
      input logic [2:0] ded,
      input pra_addr_t  lat
   );
      if (!muxed) begin
         // Page number on top, three pins below
         return {page, ded};                                 // RQ4 RQ5
      end else if (pme) begin
         // Paging on the muxed bus
         return {page, lat[`PRA_SUB_W-1:0]};                 // RQ7
      end else begin
         // Linear addressing
         return lat;                                         // RQ7
      end
   endfunction

   // Address and storage of the current access
   pra_addr_t  latched_addr;
   pra_addr_t  acc_addr;
   pra_class_e acc_class;
   pra_byte_t  mem [`PRA_NUM_REGS];

   // Six address bits taken in one address phase
   // Only reset clears it; a stale address stays live until the next phase.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         latched_addr <= '0;
      end else if (bus.ale) begin
         latched_addr <= bus.ad[`PRA_ADDR_W-1:0];            // RQ6
      end
   end

   // Effective address and class of the current access
   // Dedicated mode keeps paging even with the enable bit low.
   always_comb begin
      acc_addr  = form_addr(bus.bus_muxed, page_mode_enable, page_number,
                            bus.addr_ded, latched_addr);     // RQ1 RQ2
      acc_class = pra_classify(acc_addr);                    // RQ3 RQ13
   end

   // ==========================================
   // Page register

   // Held until the host rewrites it; decoded at sub-offset zero of any page
   // Unused bits of the page byte are dropped and read back as zero.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         page_mode_enable <= `PRA_PME_RST;
         page_number      <= `PRA_PNUM_RST;
      end else if (bus.wr && acc_class == CL_PAGE) begin     // RQ3 RQ13
         page_mode_enable <= bus.ad[`PRA_PME_BIT];           // RQ14
         page_number      <= bus.ad[`PRA_PAGE_HI:`PRA_PAGE_LO];
      end
   end

   // ==========================================
   // Register storage

   // Host writes land in read/write, dynamic and write-only slots.
   // The engine only clears the command slot; a host write in the
   // same cycle wins so a freshly issued command is never lost.
   // Page slots keep their own flops, so those array entries stay idle.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < `PRA_NUM_REGS; i++) begin
            mem[i] <= `PRA_REG_RST;
         end
      end else begin
         if (cmd_done) begin
            mem[`PRA_ADDR_CMD] <= `PRA_CMD_IDLE;             // RQ9
         end
         if (bus.wr) begin
            unique case (acc_class)
               CL_RW,
               CL_WO,
               CL_DYN: begin
                  mem[acc_addr] <= bus.ad;                   // RQ8 RQ9 RQ11
               end
               CL_RO,
               CL_PAGE: begin
                  // Read-only and page slots leave the array untouched
               end
            endcase
         end
      end
   end

   // Read-only flags follow internal state every cycle
   // One cycle behind the engine; no host write ever reaches them.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         error_flags_reg <= `PRA_REG_RST;
      end else begin
         error_flags_reg <= err_flags_in;                    // RQ10
      end
   end

   // Values the engine samples; of these it changes only the command slot
   // Plain view of the stored flops, so no extra latency.
   always_comb begin
      command_reg      = mem[`PRA_ADDR_CMD];
      timer_reload_reg = mem[`PRA_ADDR_TRLD];                // RQ8
   end

   // ==========================================
   // Read path

   // Registered answer, one cycle after the read strobe
   // Only a read strobe moves it, so the answer stands until the next read.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bus.rdata <= `PRA_REG_RST;
      end else if (bus.rd) begin
         unique case (acc_class)
            CL_PAGE: begin
               bus.rdata <= {page_mode_enable, 4'h0, page_number};
            end
            CL_RO: begin
               bus.rdata <= error_flags_reg;                 // RQ10
            end
            CL_WO: begin
               // Stored content must not leak back to the host
               bus.rdata <= UNDEF_READ;                      // RQ11
            end
            CL_RW,
            CL_DYN: begin
               bus.rdata <= mem[acc_addr];
            end
         endcase
      end
   end

   // Answer marker
   // High exactly one cycle after each read strobe.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bus.rvalid <= 1'b0;
      end else begin
         bus.rvalid <= bus.rd;
      end
   end

   // ==========================================
   // Write notification for the engine

   // Lets the engine start a command the cycle after it is written
   // Read-only writes raise no strobe; address and data still follow.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wr_strobe <= 1'b0;
         wr_addr   <= '0;
         wr_data   <= `PRA_REG_RST;
      end else begin
         wr_strobe <= bus.wr && acc_class != CL_RO;
         if (bus.wr) begin
            wr_addr <= acc_addr;
            wr_data <= bus.ad;
         end
      end
   end

endmodule
`default_nettype wire

//--- src/pra_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pra_consts.svh"
module pra_host
   import pra_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Device port
   pra_bus_if.host         bus,
   // Configuration
   input  wire logic       cfg_muxed,
   input  wire logic       cfg_linear,
   // Request
   input  wire logic       req_valid,
   input  wire logic       req_write,
   input  wire pra_addr_t  req_addr,
   input  wire pra_byte_t  req_wdata,
   output logic            req_ready,
   // Answer
   output logic            resp_valid,
   output pra_byte_t       resp_data
);

   typedef enum {S_IDLE, S_PG_ALE, S_PG_WR, S_ADDR, S_ACC, S_WAIT, S_DONE} pra_hstate_e;

   pra_hstate_e state;
   pra_addr_t   t_addr;
   pra_byte_t   t_data;
   logic        t_write;
   pra_byte_t   pg_val;
   logic        cur_pme;
   logic [2:0]  cur_page;
   logic        want_pme;
   logic        need_pg;

   // ==========================================
   // Paging decision

   // Dedicated bus always pages; muxed pages unless linear is asked
   always_comb begin
      want_pme  = cfg_muxed ? !cfg_linear : 1'b1;            // RQ5 RQ7
      need_pg   = (want_pme != cur_pme) ||
                  (want_pme && req_addr[`PRA_ADDR_W-1:`PRA_SUB_W] != cur_page);
      req_ready = (state == S_IDLE);
   end

   // ==========================================
   // Sequencer and shadow of the device page state
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state    <= S_IDLE;
         t_addr   <= '0;
         t_data   <= `PRA_REG_RST;
         t_write  <= 1'b0;
         pg_val   <= `PRA_PAGE_RST;
         cur_pme  <= `PRA_PME_RST;
         cur_page <= `PRA_PNUM_RST;
      end else begin
         unique case (state)
            S_IDLE: if (req_valid) begin
               t_addr  <= req_addr;
               t_data  <= req_wdata;
               t_write <= req_write;
               // Unused page bits written as zero
               pg_val  <= {want_pme, 4'h0,
                           req_addr[`PRA_ADDR_W-1:`PRA_SUB_W]};   // RQ12
               state   <= need_pg ? S_PG_ALE : S_ADDR;
            end
            S_PG_ALE: state <= S_PG_WR;
            S_PG_WR: begin
               cur_pme  <= pg_val[`PRA_PME_BIT];
               cur_page <= pg_val[`PRA_PAGE_HI:`PRA_PAGE_LO];
               state    <= S_ADDR;
            end
            S_ADDR: state <= S_ACC;
            S_ACC:  state <= t_write ? S_DONE : S_WAIT;
            S_WAIT: if (bus.rvalid) begin
               state <= S_IDLE;
            end
            S_DONE: begin
               // A direct page write moves the shadow too
               if (t_addr[`PRA_SUB_W-1:0] == `PRA_SUB_PAGE) begin
                  cur_pme  <= t_data[`PRA_PME_BIT];
                  cur_page <= t_data[`PRA_PAGE_HI:`PRA_PAGE_LO];
               end
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Bus drive, all from flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bus.bus_muxed <= 1'b0;
         bus.ale       <= 1'b0;
         bus.ad        <= `PRA_REG_RST;
         bus.addr_ded  <= `PRA_SUB_PAGE;
         bus.rd        <= 1'b0;
         bus.wr        <= 1'b0;
      end else begin
         bus.ale <= 1'b0;
         bus.rd  <= 1'b0;
         bus.wr  <= 1'b0;
         unique case (state)
            S_IDLE: if (req_valid) begin
               bus.bus_muxed <= cfg_muxed;
            end
            S_PG_ALE: if (bus.bus_muxed) begin
               // Sub-offset zero reaches the page register in any page
               bus.ale <= 1'b1;                                    // RQ3
               bus.ad  <= `PRA_REG_RST;
            end
            S_PG_WR: begin
               bus.addr_ded <= `PRA_SUB_PAGE;
               bus.ad       <= pg_val;                             // RQ5
               bus.wr       <= 1'b1;
            end
            S_ADDR: if (bus.bus_muxed) begin
               bus.ale <= 1'b1;                                    // RQ6
               bus.ad  <= {2'b00, t_addr};
            end
            S_ACC: begin
               bus.addr_ded <= t_addr[`PRA_SUB_W-1:0];             // RQ4
               bus.ad       <= t_data;
               bus.wr       <= t_write;
               bus.rd       <= !t_write;
            end
            S_WAIT,
            S_DONE: begin
            end
         endcase
      end
   end

   // ==========================================
   // Answer
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         resp_valid <= 1'b0;
         resp_data  <= `PRA_REG_RST;
      end else begin
         resp_valid <= (state == S_DONE) || (state == S_WAIT && bus.rvalid);
         if (state == S_WAIT && bus.rvalid) begin
            resp_data <= bus.rdata;
         end
      end
   end

endmodule
`default_nettype wire

//--- src/pra_pkg.sv
`default_nettype none
`include "pra_consts.svh"
package pra_pkg;
   // ==========================================
   // Types
   typedef logic [`PRA_ADDR_W-1:0] pra_addr_t;
   typedef logic [7:0]             pra_byte_t;
   typedef enum logic [2:0] {CL_PAGE, CL_RW, CL_DYN, CL_RO, CL_WO} pra_class_e;

   // Access class of each register address
   function automatic pra_class_e pra_classify(input pra_addr_t a);
      if (a[`PRA_SUB_W-1:0] == `PRA_SUB_PAGE) begin
         return CL_PAGE;
      end else if (a == `PRA_ADDR_CMD) begin
         return CL_DYN;
      end else if (a == `PRA_ADDR_ERR) begin
         return CL_RO;
      end else if (a[`PRA_ADDR_W-1:`PRA_SUB_W] == `PRA_WO_PAGE) begin
         return CL_WO;
      end else begin
         return CL_RW;
      end
   endfunction
endpackage
`default_nettype wire

//--- verif/paged_register_addressing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module paged_register_addressing_tb_top;
   import pra_pkg::*;
   // ==========================================
   // Stimulus and observation
   logic       core_clk = 1'b0;
   logic       nrst = 1'b0;
   logic       cfg_muxed = 1'b0;
   logic       cfg_linear = 1'b0;
   logic       req_valid = 1'b0;
   logic       req_write = 1'b0;
   pra_addr_t  req_addr = 6'h00;
   pra_byte_t  req_wdata = 8'h00;
   logic       cmd_done = 1'b0;
   logic [7:0] err_flags_in = 8'h00;
   logic       req_ready;
   logic       resp_valid;
   pra_byte_t  resp_data;
   logic [7:0] command_reg;
   logic [7:0] timer_reload_reg;
   logic [7:0] error_flags_reg;
   logic       page_mode_enable;
   logic [2:0] page_number;
   logic       wr_strobe;
   pra_addr_t  wr_addr;
   pra_byte_t  wr_data;
   logic       pme2;
   logic [2:0] pg2;
   int         errors = 0;
   int         total_checks = 0;
   int         cycles = 0;
   pra_addr_t  ads [5] = '{6'h13, 6'h2d, 6'h23, 6'h09, 6'h31};
   pra_addr_t  pgs [3] = '{6'h00, 6'h08, 6'h38};
   localparam pra_byte_t UNDEF = 8'ha5; // Distinct from reset data
   pra_bus_if bus ();
   pra_bus_if bus2 ();
   // Second port is driven by the bench to misbehave on purpose
   pra_host u_pra_host (.core_clk(core_clk), .nrst(nrst), .bus(bus), .cfg_muxed(cfg_muxed),
      .cfg_linear(cfg_linear), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data));
   pra_device #(.UNDEF_READ(UNDEF)) u_pra_device (.core_clk(core_clk), .nrst(nrst), .bus(bus),
      .cmd_done(cmd_done), .err_flags_in(err_flags_in), .command_reg(command_reg),
      .timer_reload_reg(timer_reload_reg), .error_flags_reg(error_flags_reg),
      .page_mode_enable(page_mode_enable), .page_number(page_number),
      .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
   pra_device #(.UNDEF_READ(UNDEF)) u_pra_device_2 (.core_clk(core_clk), .nrst(nrst),
      .bus(bus2), .cmd_done(1'b0), .err_flags_in(8'h00), .command_reg(),
      .timer_reload_reg(), .error_flags_reg(), .page_mode_enable(pme2),
      .page_number(pg2), .wr_strobe(), .wr_addr(), .wr_data());
   pra_bus_checker #(.UNDEF_READ(UNDEF)) u_pra_bus_checker (.core_clk(core_clk),
      .nrst(nrst), .bus_muxed(bus.bus_muxed), .ale(bus.ale), .ad(bus.ad),
      .addr_ded(bus.addr_ded), .rd(bus.rd), .wr(bus.wr), .rdata(bus.rdata),
      .rvalid(bus.rvalid));
   // Clock and hang guard
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end
   // ==========================================
   // Tasks
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Mode 0 dedicated, 1 muxed paged, 2 muxed linear
   task automatic set_mode(input int m);
      cfg_muxed = (m != 0);
      cfg_linear = (m == 2);
   endtask
   // One request held until taken, then wait for the answer
   task automatic acc(input logic w, input pra_addr_t a, input pra_byte_t d,
                      output pra_byte_t q);
      int k;
      @(posedge core_clk);
      #1;
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      // Ready is combinational: look at it settled, then let one edge take it
      while (req_ready !== 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
      k = 0;
      while (resp_valid !== 1'b1 && k < 20) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      `CHK(resp_valid, 1'b1)
      q = resp_data;
   endtask
   task automatic rd_chk(input pra_addr_t a, input pra_byte_t e);
      pra_byte_t q;
      acc(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask
   // Raw cycle on the second port, dedicated lines only
   task automatic raw_op(input logic w, input logic [2:0] s, input pra_byte_t d);
      @(posedge core_clk);
      #1;
      bus2.addr_ded = s;
      bus2.ad = d;
      bus2.wr = w;
      bus2.rd = !w;
      @(posedge core_clk);
      #1;
      `CHK(bus2.rvalid, !w)
      bus2.wr = 1'b0;
      bus2.rd = 1'b0;
      bus2.ad = ~d;
      @(posedge core_clk);
      #1;
   endtask
   // ==========================================
   // Test sequence
   initial begin
      pra_byte_t q;
      {bus2.bus_muxed, bus2.ale, bus2.rd, bus2.wr, bus2.addr_ded, bus2.ad} = '0;
      repeat (10) @(posedge core_clk);
      #1;
      nrst = 1'b1;
      `CHK(page_mode_enable, 1'b1)
      `CHK(page_number, 3'h0)
      $display("reset test done");
      // Written in one mode, read back in the next
      for (int m = 0; m < 3; m++) begin
         set_mode(m);
         foreach (ads[i]) acc(1'b1, ads[i], {2'(m), ads[i]}, q);
         `CHK(timer_reload_reg, {2'(m), 6'h23})
         `CHK(page_mode_enable, (m != 2))
         if (m == 0) `CHK(page_number, 3'h6)
         set_mode((m + 1) % 3);
         foreach (ads[i]) rd_chk(ads[i], {2'(m), ads[i]});
      end
      $display("mode test done");
      for (int m = 1; m >= 0; m--) begin
         set_mode(m);
         foreach (pgs[i]) rd_chk(pgs[i], {1'b1, 4'h0, pgs[i][5:3]});
      end
      $display("page test done");
      acc(1'b1, 6'h01, 8'h0c, q);
      `CHK(command_reg, 8'h0c)
      `CHK(wr_strobe, 1'b1)
      `CHK(wr_addr, 6'h01)
      `CHK(wr_data, 8'h0c)
      @(posedge core_clk);
      #1;
      cmd_done = 1'b1;
      @(posedge core_clk);
      #1;
      cmd_done = 1'b0;
      `CHK(command_reg, 8'h00)
      rd_chk(6'h01, 8'h00);
      err_flags_in = 8'h5a;
      acc(1'b1, 6'h0a, 8'hff, q);
      `CHK(wr_strobe, 1'b0)
      `CHK(wr_addr, 6'h0a)
      rd_chk(6'h0a, 8'h5a);
      `CHK(error_flags_reg, 8'h5a)
      acc(1'b1, 6'h3b, 8'h77, q);
      rd_chk(6'h3b, UNDEF);
      $display("class test done");
      raw_op(1'b1, 3'h0, 8'h7a);
      `CHK(pme2, 1'b0)
      `CHK(pg2, 3'h2)
      raw_op(1'b0, 3'h0, 8'h00);
      `CHK(bus2.rdata, 8'h02)
      $display("fault test done");
      summarize();
   end
endmodule
`default_nettype wire

//--- verif/pra_bus_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pra_bus_checker #(
   parameter logic [7:0] UNDEF_READ = 8'h00
)(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       nrst,
   // Host port
   input wire logic       bus_muxed,
   input wire logic       ale,
   input wire logic [7:0] ad,
   input wire logic [2:0] addr_ded,
   input wire logic       rd,
   input wire logic       wr,
   input wire logic [7:0] rdata,
   input wire logic       rvalid
);
   // ==========================================
   // Shadow of address path and storage
   logic [7:0] mem [64];
   logic [5:0] lat;
   logic       pme;
   logic [2:0] pg;
   logic [7:0] rd_exp;
   logic [7:0] rd_pg;
   logic [5:0] fa;
   logic       rw;
   logic       wo;
   // Dedicated bus keeps paging even with paging off
   assign fa = (bus_muxed && !pme) ? lat : {pg, (bus_muxed ? lat[2:0] : addr_ded)};
   assign rw = (fa[2:0] != 3'h0) && (fa != 6'h01) && (fa != 6'h0a) && (fa[5:3] != 3'h7);
   assign wo = (fa[2:0] != 3'h0) && (fa[5:3] == 3'h7);
   // Address phase latch
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lat <= 6'h00;
      end else if (ale) begin
         lat <= ad[5:0];
      end
   end
   // Storage and page state follow host writes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 64; i++) begin
            mem[i] <= 8'h00;
         end
         pme <= 1'b1;
         pg  <= 3'h0;
      end else if (wr) begin
         mem[fa] <= ad;
         if (fa[2:0] == 3'h0) begin
            pme <= ad[7];
            pg  <= ad[2:0];
         end
      end
   end
   // Expected read data, one cycle behind the strobe
   always_ff @(posedge core_clk) begin
      rd_exp <= mem[fa];
      rd_pg  <= {pme, 4'h0, pg};
   end
   // ==========================================
   // Properties
   property p_rd_answer;
      @(posedge core_clk) disable iff (!nrst) rd |=> rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rvalid_cause;
      @(posedge core_clk) disable iff (!nrst) rvalid |-> $past(rd);
   endproperty
   a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read answer");
   property p_rdata_hold;
      @(posedge core_clk) disable iff (!nrst) !rvalid |-> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_ded_read;
      @(posedge core_clk) disable iff (!nrst) rd && !bus_muxed && rw |=> rdata == rd_exp;
   endproperty
   a_ded_read: assert property (p_ded_read) else $error("dedicated read wrong");
   property p_mux_page;
      @(posedge core_clk) disable iff (!nrst) rd && bus_muxed && pme && rw |=> rdata == rd_exp;
   endproperty
   a_mux_page: assert property (p_mux_page) else $error("paged read wrong");
   property p_mux_lin;
      @(posedge core_clk) disable iff (!nrst) rd && bus_muxed && !pme && rw |=> rdata == rd_exp;
   endproperty
   a_mux_lin: assert property (p_mux_lin) else $error("linear read wrong");
   property p_page_read;
      @(posedge core_clk) disable iff (!nrst) rd && fa[2:0] == 3'h0 |=> rdata == rd_pg;
   endproperty
   a_page_read: assert property (p_page_read) else $error("page read wrong");
   property p_wo_read;
      @(posedge core_clk) disable iff (!nrst) rd && wo |=> rdata == UNDEF_READ;
   endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only read leaked");
endmodule
`default_nettype wire
